// File: design/cpu_exec_consts.vh
// Function
// - Literal load writes accumulator, flags untouched
// - Access bit 0 access bank, 1 bank select
// - Extended set, access 0, addr<=95 indexed offset
// - Literal multiply gives 16-bit product high/low
// - File multiply into product, sources unchanged
// - Multiplies never touch any status flag
// - Negate file, update N OV C DC Z
// - Relative call pushes PC+2, jumps PC+2+2n
// - Relative call two cycles, second is idle
// - Software reset restarts like master clear reset
`ifndef CPU_EXEC_CONSTS_VH
`define CPU_EXEC_CONSTS_VH
`define OPC_LOAD_LIT    8'h0E
`define OPC_MUL_LIT     8'h0D
`define OPC6_MUL_FILE   6'h00
`define OPC7_STORE      7'h37
`define OPC7_NEGATE     7'h36
`define OPC5_RELATIVE_SUBROUTINE_CALL      5'h1B
`define WORD_NOP        16'h0000
`define WORD_POP        16'h0006
`define WORD_PUSH       16'h0005
`define WORD_RESET      16'h00FF
`define OPC4_NOP_EXT    4'hF
`define INDEX_LIMIT     8'h5F
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF
`define STACK_DEPTH     31
`define STACK_PTR_W     5
`define PC_W            21
`define FLAG_N          4
`define FLAG_OV         3
`define FLAG_Z          2
`define FLAG_DC         1
`define FLAG_C          0
`define PHASE_RESET     2'd1
`define PHASE_LAST      2'd3
`endif

// File: design/return_stack.v
`timescale 1ns/100ps
`include "cpu_exec_consts.vh"
module return_stack (
  // Clock and reset
  input  wire                    i_clock,
  input  wire                    i_rst,
  // Controls
  input  wire                    i_push,
  input  wire                    i_pop,
  input  wire [`PC_W-1:0]        i_data,
  // State
  output reg  [`PC_W-1:0]        o_top,
  output reg  [`STACK_PTR_W-1:0] o_ptr
);
  reg [`PC_W-1:0] mem_reg [0:`STACK_DEPTH];
  integer i;
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_ptr <= {`STACK_PTR_W{1'b0}};
      o_top <= {`PC_W{1'b0}};
      for (i = 0; i <= `STACK_DEPTH; i = i + 1) begin
        mem_reg[i] <= {`PC_W{1'b0}};
      end
    end else if (i_push) begin
      // Older entries stay below; the new one becomes top
      mem_reg[o_ptr + 5'd1] <= i_data;
      o_ptr <= o_ptr + 5'd1;
      o_top <= i_data;
    end else if (i_pop) begin
      o_ptr <= o_ptr - 5'd1;
      o_top <= mem_reg[o_ptr - 5'd1];
    end
  end
endmodule

// File: design/cpu_move_mul_call_exec.v
`timescale 1ns/100ps
`include "cpu_exec_consts.vh"
module cpu_move_mul_call_exec (
  // Clock and reset
  input  wire                    i_clock,
  input  wire                    i_rst,
  // Instruction stream
  input  wire                    i_instr_valid,
  input  wire [15:0]             i_instr,
  input  wire                    i_ext_enable,
  // Data memory read data for the addressed operand
  input  wire [7:0]              i_file_rdata,
  // Core state outputs
  output reg  [7:0]              o_acc,
  output reg  [7:0]              o_product_high_byte,
  output reg  [7:0]              o_product_low_byte,
  output reg  [4:0]              o_status,
  output reg  [`PC_W-1:0]        o_pc,
  output reg  [`PC_W-1:0]        o_return_stack_top,
  output reg  [`STACK_PTR_W-1:0] o_stack_ptr,
  output reg  [7:0]              o_bank_select_register,
  // Data memory access
  output reg  [11:0]             o_file_addr,
  output reg                     o_file_rd,
  output reg                     o_file_we,
  output reg  [7:0]              o_file_wdata,
  output reg                     o_indexed_mode,
  // Sequencing
  output reg  [1:0]              o_phase,
  output reg                     o_busy,
  output reg                     o_soft_reset
);

  ////////////////////////////////////////////////////////////////////
  // Instruction phase counter: four phases form one instruction cycle

  reg [1:0] phase_reg;

  reg        reset_pend_reg;
  wire       core_rst = i_rst | reset_pend_reg;

  always @(posedge i_clock) begin
    if (core_rst) begin
      phase_reg <= 2'd0;
    end else begin
      phase_reg <= phase_reg + 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode

  localparam ST_RUN   = 1'b0;
  localparam ST_SLOT2 = 1'b1;
  reg state_reg;

  reg [15:0] ir_reg;
  wire [7:0] lit   = ir_reg[7:0];
  wire       acc_b = ir_reg[8];
  wire is_load  = (ir_reg[15:8] == `OPC_LOAD_LIT);
  wire is_mull  = (ir_reg[15:8] == `OPC_MUL_LIT);
  wire is_mulf  = (ir_reg[15:10] == `OPC6_MUL_FILE) &&
                  (ir_reg[9] == 1'b1);
  wire is_store = (ir_reg[15:9] == `OPC7_STORE);
  wire is_neg   = (ir_reg[15:9] == `OPC7_NEGATE);
  wire is_relative_subroutine_call = (ir_reg[15:11] == `OPC5_RELATIVE_SUBROUTINE_CALL);
  wire is_push  = (ir_reg == `WORD_PUSH);
  wire is_pop   = (ir_reg == `WORD_POP);
  wire is_reset = (ir_reg == `WORD_RESET);
  wire uses_file = is_mulf | is_store | is_neg;

  ////////////////////////////////////////////////////////////////////
  // Operand address

  reg [11:0] addr_next;
  reg        indexed_next;
  always @* begin
    indexed_next = 1'b0;
    if (acc_b) begin
      addr_next = {o_bank_select_register[3:0], lit};
    end else if (i_ext_enable && lit <= `INDEX_LIMIT) begin
      // Offset is passed raw; the address unit adds the index base
      indexed_next = 1'b1;
      addr_next = {4'h0, lit};
    end else if (lit < `ACCESS_SPLIT) begin
      addr_next = {4'h0, lit};
    end else begin
      addr_next = {`ACCESS_HI_BANK, lit};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Arithmetic

  wire [15:0] prod_lit  = o_acc * lit;
  wire [15:0] prod_file = o_acc * i_file_rdata;
  wire [8:0]  neg_sum   = {1'b0, ~i_file_rdata} + 9'h001;
  wire [4:0]  neg_nib   = {1'b0, ~i_file_rdata[3:0]} + 5'h01;
  wire [7:0]  neg_val   = neg_sum[7:0];
  wire        neg_ov    = (i_file_rdata == 8'h80);

  wire [10:0] offs   = ir_reg[10:0];
  wire [`PC_W-1:0] pc_plus2 = o_pc + 21'd2;
  wire [`PC_W-1:0] relative_subroutine_call_tgt =
    pc_plus2 + {{9{offs[10]}}, offs, 1'b0};

  reg  stk_push;
  reg  stk_pop;
  wire [`PC_W-1:0]        stk_top;
  wire [`STACK_PTR_W-1:0] stk_ptr;

  return_stack u_stack (
    .i_clock (i_clock),
    .i_rst   (core_rst),
    .i_push  (stk_push),
    .i_pop   (stk_pop),
    .i_data  (pc_plus2),
    .o_top   (stk_top),
    .o_ptr   (stk_ptr)
  );

  ////////////////////////////////////////////////////////////////////
  // Execution: Q1 latch, Q2 read, Q3 process and write, Q4 PC update

  always @* begin
    stk_push = 1'b0;
    stk_pop  = 1'b0;
    if (!core_rst && state_reg == ST_RUN) begin
      if (phase_reg == 2'd1 && (is_push || is_relative_subroutine_call)) begin
        stk_push = 1'b1;
      end
      if (phase_reg == 2'd2 && is_pop) begin
        stk_pop = 1'b1;
      end
    end
  end

  always @(posedge i_clock) begin
    if (core_rst) begin
      o_acc                  <= 8'h00;
      o_product_high_byte    <= 8'h00;
      o_product_low_byte     <= 8'h00;
      o_status               <= 5'h00;
      o_pc                   <= {`PC_W{1'b0}};
      o_bank_select_register <= 8'h00;
      o_file_addr            <= 12'h000;
      o_file_rd              <= 1'b0;
      o_file_we              <= 1'b0;
      o_file_wdata           <= 8'h00;
      o_indexed_mode         <= 1'b0;
      o_busy                 <= 1'b0;
      ir_reg                 <= `WORD_NOP;
      state_reg              <= ST_RUN;
      reset_pend_reg         <= 1'b0;
    end else begin
      o_file_we <= 1'b0;
      o_file_rd <= 1'b0;
      case (phase_reg)
        2'd0: begin
          if (state_reg == ST_RUN && i_instr_valid) begin
            ir_reg <= i_instr;
          end else begin
            ir_reg <= `WORD_NOP;
          end
        end
        `PHASE_RESET: begin
          if (state_reg == ST_RUN && is_reset) begin
            reset_pend_reg <= 1'b1;
          end
          if (uses_file) begin
            o_file_addr    <= addr_next;
            o_indexed_mode <= indexed_next;
            // Every file operand is read in Q2, the store included
            o_file_rd      <= 1'b1;
          end
        end
        2'd2: begin
          if (state_reg == ST_RUN) begin
            if (is_load) begin
              o_acc <= lit;
            end
            if (is_mull) begin
              o_product_high_byte <= prod_lit[15:8];
              o_product_low_byte  <= prod_lit[7:0];
            end
            if (is_mulf) begin
              o_product_high_byte <= prod_file[15:8];
              o_product_low_byte  <= prod_file[7:0];
            end
            if (is_store) begin
              o_file_wdata <= o_acc;
              o_file_we    <= 1'b1;
            end
            if (is_neg) begin
              o_file_wdata <= neg_val;
              o_file_we    <= 1'b1;
              o_status[`FLAG_N]  <= neg_val[7];
              o_status[`FLAG_OV] <= neg_ov;
              o_status[`FLAG_Z]  <= (neg_val == 8'h00);
              o_status[`FLAG_DC] <= neg_nib[4];
              o_status[`FLAG_C]  <= neg_sum[8];
            end
          end
        end
        default: begin
          if (state_reg == ST_SLOT2) begin
            state_reg <= ST_RUN;
            o_busy    <= 1'b0;
            o_pc      <= o_pc;
          end else if (is_relative_subroutine_call) begin
            o_pc      <= relative_subroutine_call_tgt;
            state_reg <= ST_SLOT2;
            o_busy    <= 1'b1;
          end else if (i_instr_valid || ir_reg != `WORD_NOP) begin
            o_pc <= pc_plus2;
          end
        end
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_phase            <= 2'd0;
      o_return_stack_top <= {`PC_W{1'b0}};
      o_stack_ptr        <= {`STACK_PTR_W{1'b0}};
      o_soft_reset       <= 1'b0;
    end else begin
      o_phase            <= phase_reg;
      o_return_stack_top <= stk_top;
      o_stack_ptr        <= stk_ptr;
      o_soft_reset       <= reset_pend_reg;
    end
  end

endmodule

// File: testbench/cpu_exec_chk_sva.sv
`timescale 1ns/100ps
module cpu_exec_chk (
  // Clock, reset and operand data
  input wire        i_clock,
  input wire        i_rst,
  input wire [7:0]  i_file_rdata,
  // Observed core state
  input wire [7:0]  o_acc,
  input wire [7:0]  o_product_high_byte,
  input wire [7:0]  o_product_low_byte,
  input wire [4:0]  o_status,
  input wire [4:0]  o_stack_ptr,
  input wire [11:0] o_file_addr,
  input wire        o_file_rd,
  input wire        o_file_we,
  input wire [7:0]  o_file_wdata,
  input wire        o_indexed_mode,
  input wire        o_busy
);
  wire [15:0] prod = {o_product_high_byte, o_product_low_byte};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_read_one_pulse: assert property (o_file_rd |=> !o_file_rd)
    else $error("file read strobe longer than one clock");
  a_write_after_read: assert property (o_file_we |-> $past(o_file_rd))
    else $error("file write not preceded by a read");
  a_write_data_src: assert property (o_file_we |-> o_file_wdata == o_acc
    || o_file_wdata == 8'h00 - $past(i_file_rdata))
    else $error("file write data is neither acc nor negated operand");
  a_negate_flags: assert property (o_file_we && $changed(o_status) |->
    o_status[2] == (o_file_wdata == 8'h00) && o_status[4] == o_file_wdata[7])
    else $error("negate zero or negative flag wrong");
  // Zero products are excluded because reset also clears the status
  a_mul_keeps_flags: assert property ($changed(prod) && prod != 0
    |-> $stable(o_status)) else $error("multiply changed status");
  a_mul_keeps_acc: assert property ($changed(prod) && prod != 0
    |-> $stable(o_acc)) else $error("multiply changed acc");
  a_load_keeps_flags: assert property ($changed(o_acc) && o_acc != 0
    |-> $stable(o_status)) else $error("literal load changed status");
  a_stack_ptr_step: assert property ($changed(o_stack_ptr) |->
    o_stack_ptr == $past(o_stack_ptr) + 5'd1 || o_stack_ptr == 5'd0
    || o_stack_ptr == $past(o_stack_ptr) - 5'd1)
    else $error("stack pointer jumped");
  a_call_idle_len: assert property ($rose(o_busy) |->
    o_busy [*4] ##1 !o_busy) else $error("call idle slot not four clocks");
  a_indexed_range: assert property (o_indexed_mode && o_file_rd
    |-> o_file_addr <= 12'h05F) else $error("indexed offset above limit");
endmodule
bind cpu_move_mul_call_exec cpu_exec_chk cpu_exec_chk_i (
  .i_clock, .i_rst, .i_file_rdata, .o_acc, .o_product_high_byte,
  .o_product_low_byte, .o_status, .o_stack_ptr, .o_file_addr, .o_file_rd,
  .o_file_we, .o_file_wdata, .o_indexed_mode, .o_busy);

// File: testbench/cpu_move_mul_call_exec_tb.sv
`timescale 1ns/100ps
module cpu_move_mul_call_exec_tb;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_instr_valid = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic        i_ext_enable = 1'b0;
  logic [7:0]  i_file_rdata = 8'h00;
  wire  [7:0]  o_acc, o_product_high_byte, o_product_low_byte;
  wire  [7:0]  o_bank_select_register, o_file_wdata;
  wire  [4:0]  o_status, o_stack_ptr;
  wire  [20:0] o_pc, o_return_stack_top;
  wire  [11:0] o_file_addr;
  wire  [1:0]  o_phase;
  wire         o_file_rd, o_file_we, o_indexed_mode, o_busy, o_soft_reset;
  integer      miscompares = 0;
  integer      n_checks = 0;
  logic [20:0] pc_exp = 21'd2;
  logic [7:0]  rdat = 8'h00;
  logic        ext = 1'b0;
  logic [15:0] sw [6] = '{16'h6F25, 16'h6E80, 16'h6E10,
                          16'h6E5F, 16'h6E60, 16'h6F10};
  logic [7:0]  nd [3] = '{8'h3A, 8'h00, 8'h80};
  logic [15:0] rw [2] = '{16'hDC00, 16'hDBFF};

  cpu_move_mul_call_exec cpu_move_mul_call_exec_i (
    .i_clock, .i_rst, .i_instr_valid, .i_instr, .i_ext_enable,
    .i_file_rdata, .o_acc, .o_product_high_byte, .o_product_low_byte,
    .o_status, .o_pc, .o_return_stack_top, .o_stack_ptr,
    .o_bank_select_register, .o_file_addr, .o_file_rd, .o_file_we,
    .o_file_wdata, .o_indexed_mode, .o_phase, .o_busy, .o_soft_reset);

  always #2 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] s, input logic [63:0] e, input string n);
    n_checks = n_checks + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("ERROR %s exp %0h seen %0h", n, e, s);
    end
  endtask

  task end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Driven at the slot's last edge; pc lags one slot, so it is checked here
  task issue(input logic [15:0] w);
    @(posedge i_clock);
    i_instr <= w;
    i_ext_enable <= ext;
    i_file_rdata <= rdat;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    if (w != 16'h00FF) begin
      chk(o_pc, pc_exp, "pc");
      chk(o_phase, 2'd2, "phase");
    end
    pc_exp = pc_exp + 21'd2;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_mul;
    rdat = 8'hB5;
    issue(16'h0EE2);
    issue(16'h0DC4);
    chk({o_product_high_byte, o_product_low_byte, o_acc}, 24'hAD08E2, "mull");
    issue(16'h0EC4);
    issue(16'h0325);
    chk({o_product_high_byte, o_product_low_byte, o_acc, o_file_we},
        {24'h8A94C4, 1'b0}, "mulf");
  endtask

  task t_store;
    logic [7:0] f;
    issue(16'h0E4F);
    for (int i = 0; i < 6; i++) begin
      ext = (i > 2);
      f = sw[i][7:0];
      issue(sw[i]);
      chk(o_file_addr, {(!sw[i][8] && f > 8'h5F) ? 4'hF : 4'h0, f}, "addr");
      chk(o_indexed_mode, ext && !sw[i][8] && f < 8'h60, "idx");
      chk({o_file_we, o_file_wdata, o_acc}, {1'b1, 16'h4F4F}, "store");
    end
    ext = 1'b0;
  endtask

  task t_neg;
    logic [7:0] d, r;
    for (int i = 0; i < 3; i++) begin
      d = nd[i];
      r = 8'h00 - d;
      rdat = d;
      issue(16'h6D40);
      chk({o_file_we, o_file_wdata}, {1'b1, r}, "neg");
      chk(o_status, {r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0,
          d == 8'h00}, "flags");
    end
  endtask

  // Runs with flags set so that a stray flag update is visible
  task t_flags_kept;
    issue(16'h0D00);
    chk({o_product_high_byte, o_product_low_byte, o_status}, 21'h1A, "mulz");
    issue(16'h0E5A);
    chk({o_acc, o_status}, {8'h5A, 5'h1A}, "load");
  endtask

  task t_stack;
    logic [20:0] a;
    a = pc_exp;
    issue(16'h0005);
    issue(16'hF123);
    chk({o_return_stack_top, o_stack_ptr}, {a + 21'd2, 5'd1}, "push");
    issue(16'h0006);
    issue(16'h0000);
    chk(o_stack_ptr, 5'd0, "pop");
  endtask

  task t_relative_subroutine_call;
    logic [20:0] a, t;
    for (int i = 0; i < 2; i++) begin
      a = pc_exp;
      t = a + 21'd2 + {{9{rw[i][10]}}, rw[i][10:0], 1'b0};
      issue(rw[i]);
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk({o_busy, o_pc, o_return_stack_top}, {1'b1, t, a + 21'd2}, "relative_subroutine_call");
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      pc_exp = t;
    end
  endtask

  // The reset word is swapped for a load before the restarted core samples
  task t_reset;
    @(posedge i_clock);
    i_instr <= 16'h00FF;
    repeat (2) @(posedge i_clock);
    i_instr <= 16'h0E33;
    @(posedge i_clock);
    @(negedge i_clock);
    chk({o_soft_reset, o_status, o_acc, o_pc}, {1'b1, 34'h0}, "reset");
    @(posedge i_clock);
    @(negedge i_clock);
    chk({o_soft_reset, o_stack_ptr, o_bank_select_register},
        14'h0, "reset2");
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk({o_acc, o_pc}, {8'h33, 21'd0}, "restart");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    t_mul;
    t_store;
    t_neg;
    t_flags_kept;
    t_stack;
    t_relative_subroutine_call;
    t_reset;
    end_of_test;
  end

  // Whole sequence is under 200 clocks; this bound only catches a hang
  initial begin
    #10000;
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule
